// *** design/flash_sw_defs.svh ***
`ifndef FLASH_SW_DEFS_SVH
`define FLASH_SW_DEFS_SVH

// status register low: bit positions
`define SR_BUSY          0
`define SR_LATCH         1
`define SR_GUARD_LO      2
`define SR_GUARD_HI      6
`define SR_LOCK_LO       7
// status register mid: bit positions
`define SR_LOCK_HI       0
`define SR_QUAD          1
`define SR_PROG_PAUSED   2
`define SR_OTP_LO        3
`define SR_OTP_HI        5
`define SR_CMP           6
`define SR_ERASE_PAUSED  7
// status register high: bit positions
`define SR_DUMMY         0
`define SR_DRV_LO        5
`define SR_DRV_HI        6

// power-up values of the three status registers
`define LOW_RESET        8'h00
`define MID_RESET        8'h00
`define HIGH_RESET       8'h20

// address spans of the array operations
`define ADDR_MSB         21
`define ADDR_TOP         22'h3fffff
`define PAGE_SPAN        22'h0000ff
`define SECTOR_SPAN      22'h000fff
`define BLOCK32_SPAN     22'h007fff
`define BLOCK64_SPAN     22'h00ffff

// operation times and clock period
`define CLK_PERIOD_NS    4
`define SR_WRITE_TIME_US 2000
`define PAGE_TIME_US     600
`define SECTOR_TIME_US   45000
`define BLOCK32_TIME_US  120000
`define BLOCK64_TIME_US  150000
`define CHIP_TIME_US     1000000

`endif

// *** design/flash_sw_pkg.sv ***
package flash_sw_pkg;

    // commands delivered by the command shifter
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_WREN,
        CMD_WRDI,
        CMD_STATUS_WRITE_CMD,
        CMD_PAGE,
        CMD_SECTOR,
        CMD_BLOCK32,
        CMD_BLOCK64,
        CMD_CHIP,
        CMD_SUSPEND,
        CMD_RESUME,
        CMD_SWRESET
    } cmd_t;

    // write engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_PAUSED
    } state_t;

    // kind of operation in flight
    typedef enum logic [1:0] {
        OP_STATUS,
        OP_PROGRAM,
        OP_ERASE
    } op_t;

endpackage

// *** design/op_timer.sv ***
`timescale 1ns/1ps
module op_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    input  wire logic         hold,
    input  wire logic         abort,
    output logic              running,
    output logic              done
);
    logic [W-1:0] count;

    // countdown, frozen while held; abort wins over everything
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count   <= '0;
            running <= 1'b0;
        end else if (abort) begin
            count   <= '0;
            running <= 1'b0;
        end else if (start) begin
            count   <= load;
            running <= 1'b1;
        end else if (running && !hold) begin
            if (count <= W'(1)) begin
                running <= 1'b0;
            end else begin
                count <= count - W'(1);
            end
        end
    end

    // one-cycle pulse as the count expires
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else begin
            done <= running && !hold && !abort && !start && (count <= W'(1));
        end
    end
endmodule

// *** design/guard_decode.sv ***
`timescale 1ns/1ps
`include "flash_sw_defs.svh"
module guard_decode (
    input  wire logic [4:0]  guard,
    input  wire logic        complement,
    input  wire logic [21:0] addr_first,
    input  wire logic [21:0] addr_last,
    output logic             hit
);
    // true when addr lies in the range picked by the guard code
    function automatic logic in_range(input logic [4:0] g, input logic [21:0] a);
        logic [2:0]  k;
        logic [4:0]  e;
        logic        r;
        begin
            k = g[2:0];
            e = 5'd0;
            if (k == 3'h0) begin
                r = 1'b0;
            end else if (k == 3'h7) begin
                r = 1'b1;
            end else begin
                // 4k granules above, 64k blocks below; sizes cap at 32k for small granules
                e = g[4] ? (5'd11 + ((k > 3'h4) ? 5'd4 : {2'h0, k})) : (5'd15 + {2'h0, k});
                r = g[3] ? ((a >> e) == 22'h0) : ((a >> e) == (`ADDR_TOP >> e));
            end
            in_range = r;
        end
    endfunction

    always_comb begin
        hit = (in_range(guard, addr_first) ^ complement) | (in_range(guard, addr_last) ^ complement);
    end
endmodule

// *** design/flash_status_write_protect.sv ***
`timescale 1ns/1ps
`include "flash_sw_defs.svh"
module flash_status_write_protect #(
    parameter int unsigned SR_WRITE_CYCLES = `SR_WRITE_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int unsigned PAGE_CYCLES     = `PAGE_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int unsigned SECTOR_CYCLES   = `SECTOR_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int unsigned BLOCK32_CYCLES  = `BLOCK32_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int unsigned BLOCK64_CYCLES  = `BLOCK64_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int unsigned CHIP_CYCLES     = `CHIP_TIME_US * 1000 / `CLK_PERIOD_NS
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               cmd_valid,
    input  wire flash_sw_pkg::cmd_t cmd_op,
    input  wire logic [1:0]         cmd_reg_sel,
    input  wire logic [7:0]         cmd_data,
    input  wire logic [21:0]        cmd_addr,
    input  wire logic               write_guard_pin_n,
    input  wire logic               pause_pin_n,
    output logic [7:0]              status_reg_low,
    output logic [7:0]              status_reg_mid,
    output logic [7:0]              status_reg_high,
    output logic                    busy_flag,
    output logic                    cmd_done,
    output logic                    cmd_refused,
    output logic                    quad_lines_active,
    output logic                    serial_paused
);
    flash_sw_pkg::state_t state;
    flash_sw_pkg::state_t next_state;
    flash_sw_pkg::op_t    op_kind;
    logic        guard_meta;
    logic        guard_sync;
    logic        pause_meta;
    logic        pause_sync;
    logic [1:0]  lock_mode;
    logic        quad_on;
    logic        latch;
    logic        idle;
    logic        status_write_ok;
    logic        wipe_ok;
    logic        prot_hit;
    logic        accept;
    logic        is_array_write;
    logic        starts_timer;
    logic [21:0] span;
    logic [21:0] addr_first;
    logic [21:0] addr_last;
    logic [31:0] load_cycles;
    logic        timer_running;
    logic        timer_done;

    // pins arrive from outside the clock domain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_meta <= 1'b1;
            guard_sync <= 1'b1;
            pause_meta <= 1'b1;
            pause_sync <= 1'b1;
        end else begin
            guard_meta <= write_guard_pin_n;
            guard_sync <= guard_meta;
            pause_meta <= pause_pin_n;
            pause_sync <= pause_meta;
        end
    end

    // decoded fields of the stored registers
    assign lock_mode = {status_reg_mid[`SR_LOCK_HI], status_reg_low[`SR_LOCK_LO]};
    assign quad_on   = status_reg_mid[`SR_QUAD];
    assign latch     = status_reg_low[`SR_LATCH];
    assign idle      = (state == flash_sw_pkg::ST_IDLE);

    // open mode needs only the latch
    // guard pin low locks mode 01
    // mode 10 locked until power cycle
    // in quad mode the guard pin carries data, so it cannot lock
    always_comb begin
        case (lock_mode)
            2'b00:   status_write_ok = 1'b1;
            2'b01:   status_write_ok = quad_on || guard_sync;
            default: status_write_ok = 1'b0;
        endcase
    end

    // wipe only with fully matching code
    assign wipe_ok = (status_reg_low[4:2] == 3'h0 && !status_reg_mid[`SR_CMP]) ||
                     (status_reg_low[4:2] == 3'h7 && status_reg_mid[`SR_CMP]);

    // operation footprint; a 64k block may straddle a 4k-granular boundary, so test both ends
    always_comb begin
        case (cmd_op)
            flash_sw_pkg::CMD_PAGE:    span = `PAGE_SPAN;
            flash_sw_pkg::CMD_SECTOR:  span = `SECTOR_SPAN;
            flash_sw_pkg::CMD_BLOCK32: span = `BLOCK32_SPAN;
            default:                   span = `BLOCK64_SPAN;
        endcase
    end
    assign addr_first = cmd_addr & ~span;
    assign addr_last  = cmd_addr | span;

    guard_decode u_guard (
        .guard      (status_reg_low[`SR_GUARD_HI:`SR_GUARD_LO]),
        .complement (status_reg_mid[`SR_CMP]),
        .addr_first (addr_first),
        .addr_last  (addr_last),
        .hit        (prot_hit)
    );

    assign is_array_write = (cmd_op == flash_sw_pkg::CMD_PAGE) || (cmd_op == flash_sw_pkg::CMD_SECTOR) ||
                            (cmd_op == flash_sw_pkg::CMD_BLOCK32) || (cmd_op == flash_sw_pkg::CMD_BLOCK64);

    // acceptance of each command; anything refused leaves state alone
    always_comb begin
        case (cmd_op)
            flash_sw_pkg::CMD_WREN,
            flash_sw_pkg::CMD_WRDI:    accept = idle;
            flash_sw_pkg::CMD_STATUS_WRITE_CMD:    accept = idle && latch && status_write_ok && (cmd_reg_sel != 2'h3);
            flash_sw_pkg::CMD_PAGE,
            flash_sw_pkg::CMD_SECTOR,
            flash_sw_pkg::CMD_BLOCK32,
            flash_sw_pkg::CMD_BLOCK64: accept = idle && latch && !prot_hit;
            flash_sw_pkg::CMD_CHIP:    accept = idle && latch && wipe_ok;
            flash_sw_pkg::CMD_SUSPEND: accept = (state == flash_sw_pkg::ST_BUSY) &&
                                                (op_kind != flash_sw_pkg::OP_STATUS);
            flash_sw_pkg::CMD_RESUME:  accept = (state == flash_sw_pkg::ST_PAUSED);
            flash_sw_pkg::CMD_SWRESET: accept = 1'b1;
            default:                   accept = 1'b0;
        endcase
        accept = accept && cmd_valid;
    end

    assign starts_timer = accept && (is_array_write || cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD ||
                                     cmd_op == flash_sw_pkg::CMD_CHIP);

    // duration of the accepted operation
    always_comb begin
        case (cmd_op)
            flash_sw_pkg::CMD_PAGE:    load_cycles = 32'(PAGE_CYCLES);
            flash_sw_pkg::CMD_SECTOR:  load_cycles = 32'(SECTOR_CYCLES);
            flash_sw_pkg::CMD_BLOCK32: load_cycles = 32'(BLOCK32_CYCLES);
            flash_sw_pkg::CMD_BLOCK64: load_cycles = 32'(BLOCK64_CYCLES);
            flash_sw_pkg::CMD_CHIP:    load_cycles = 32'(CHIP_CYCLES);
            default:                   load_cycles = 32'(SR_WRITE_CYCLES);
        endcase
    end

    op_timer #(
        .W (32)
    ) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (starts_timer),
        .load    (load_cycles),
        .hold    (state == flash_sw_pkg::ST_PAUSED),
        .abort   (accept && cmd_op == flash_sw_pkg::CMD_SWRESET),
        .running (timer_running),
        .done    (timer_done)
    );

    // engine sequencing
    always_comb begin
        next_state = state;
        case (state)
            flash_sw_pkg::ST_IDLE: begin
                if (starts_timer) begin
                    next_state = flash_sw_pkg::ST_BUSY;
                end
            end
            flash_sw_pkg::ST_BUSY: begin
                if (timer_done) begin
                    next_state = flash_sw_pkg::ST_IDLE;
                end else if (accept && cmd_op == flash_sw_pkg::CMD_SUSPEND) begin
                    next_state = flash_sw_pkg::ST_PAUSED;
                end
            end
            flash_sw_pkg::ST_PAUSED: begin
                if (accept && cmd_op == flash_sw_pkg::CMD_RESUME) begin
                    next_state = flash_sw_pkg::ST_BUSY;
                end
            end
            default: next_state = flash_sw_pkg::ST_IDLE;
        endcase
        if (accept && cmd_op == flash_sw_pkg::CMD_SWRESET) begin
            next_state = flash_sw_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= flash_sw_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // remembers which paused bit a suspend should raise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_kind <= flash_sw_pkg::OP_STATUS;
        end else if (starts_timer) begin
            if (cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD) begin
                op_kind <= flash_sw_pkg::OP_STATUS;
            end else if (cmd_op == flash_sw_pkg::CMD_PAGE) begin
                op_kind <= flash_sw_pkg::OP_PROGRAM;
            end else begin
                op_kind <= flash_sw_pkg::OP_ERASE;
            end
        end
    end

    // low register: lock bit, block_guard, latch, busy
    // low register layout
    // latch cleared on completion and reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg_low <= `LOW_RESET;
        end else begin
            // guard bits only via status write
            if (accept && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && cmd_reg_sel == 2'h0) begin
                status_reg_low[7:2] <= cmd_data[7:2];
            end
            if (accept && cmd_op == flash_sw_pkg::CMD_WREN) begin
                status_reg_low[`SR_LATCH] <= 1'b1;
            end else if (timer_done || (accept && (cmd_op == flash_sw_pkg::CMD_WRDI ||
                                                   cmd_op == flash_sw_pkg::CMD_SWRESET))) begin
                status_reg_low[`SR_LATCH] <= 1'b0;
            end
            status_reg_low[`SR_BUSY] <= (next_state == flash_sw_pkg::ST_BUSY);
        end
    end

    // mid register; otp locks only ever gain ones, paused bits are hardware-owned
    // mid register layout
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg_mid <= `MID_RESET;
        end else begin
            if (accept && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && cmd_reg_sel == 2'h1) begin
                status_reg_mid[`SR_CMP]                  <= cmd_data[`SR_CMP];
                status_reg_mid[`SR_OTP_HI:`SR_OTP_LO]    <= status_reg_mid[`SR_OTP_HI:`SR_OTP_LO] |
                                                            cmd_data[`SR_OTP_HI:`SR_OTP_LO];
                status_reg_mid[`SR_QUAD]                 <= cmd_data[`SR_QUAD];
                status_reg_mid[`SR_LOCK_HI]              <= cmd_data[`SR_LOCK_HI];
            end
            if (accept && cmd_op == flash_sw_pkg::CMD_SUSPEND) begin
                status_reg_mid[`SR_ERASE_PAUSED] <= (op_kind == flash_sw_pkg::OP_ERASE);
                status_reg_mid[`SR_PROG_PAUSED]  <= (op_kind == flash_sw_pkg::OP_PROGRAM);
            end else if (accept && (cmd_op == flash_sw_pkg::CMD_RESUME ||
                                    cmd_op == flash_sw_pkg::CMD_SWRESET)) begin
                status_reg_mid[`SR_ERASE_PAUSED] <= 1'b0;
                status_reg_mid[`SR_PROG_PAUSED]  <= 1'b0;
            end
        end
    end

    // high register; reserved bits always read zero
    // high register layout
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg_high <= `HIGH_RESET;
        end else if (accept && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && cmd_reg_sel == 2'h2) begin
            status_reg_high <= {1'b0, cmd_data[`SR_DRV_HI:`SR_DRV_LO], 4'h0, cmd_data[`SR_DUMMY]};
        end
    end

    // command answer pulses and registered busy copy
    // refusals only pulse cmd_refused
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_done    <= 1'b0;
            cmd_refused <= 1'b0;
            busy_flag   <= 1'b0;
        end else begin
            cmd_done    <= accept;
            cmd_refused <= cmd_valid && (cmd_op != flash_sw_pkg::CMD_NOP) && !accept;
            busy_flag   <= (next_state == flash_sw_pkg::ST_BUSY);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quad_lines_active <= 1'b0;
            serial_paused     <= 1'b0;
        end else begin
            quad_lines_active <= quad_on;
            serial_paused     <= !quad_on && !pause_sync;
        end
    end

    sequence seq_write_req;
        cmd_valid && (is_array_write || cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD || cmd_op == flash_sw_pkg::CMD_CHIP);
    endsequence

    sequence seq_refused_quiet;
        cmd_refused && !busy_flag ##1 !busy_flag;
    endsequence

    a_latch_gates_write: assert property (@(posedge clk) disable iff (!reset_n)
        seq_write_req and (idle && !latch) |=> seq_refused_quiet)
        else $error("write accepted without latch");

    a_busy_on_accept: assert property (@(posedge clk) disable iff (!reset_n)
        starts_timer |=> busy_flag && status_reg_low[`SR_BUSY] && cmd_done)
        else $error("accepted write did not raise busy");

    a_protected_refused: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && is_array_write && prot_hit |=> cmd_refused ##1 !busy_flag)
        else $error("protected area write accepted");

    a_wipe_gate: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_op == flash_sw_pkg::CMD_CHIP && !wipe_ok |=> cmd_refused && !busy_flag)
        else $error("wipe ran with a partial guard code");

    a_lock_holds_regs: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && lock_mode[1] |=>
            $stable(status_reg_low[7:2]) && $stable(status_reg_mid) && $stable(status_reg_high))
        else $error("status write passed a lock");

    a_pin_lock: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && lock_mode == 2'b01 && !quad_on && !guard_sync
            |=> cmd_refused && $stable(status_reg_low[7:2]))
        else $error("guard pin low did not lock status");

    a_open_mode: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_op == flash_sw_pkg::CMD_STATUS_WRITE_CMD && lock_mode == 2'b00 && latch && idle &&
        cmd_reg_sel == 2'h0 |=> busy_flag && status_reg_low[7:2] == $past(cmd_data[7:2]))
        else $error("open mode refused a status write");

    a_latch_clears: assert property (@(posedge clk) disable iff (!reset_n)
        timer_done |=> !status_reg_low[`SR_LATCH] && !busy_flag)
        else $error("latch survived completion");

    a_quad_pins: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(quad_on) |=> quad_lines_active && !serial_paused)
        else $error("pins kept control role in quad mode");
endmodule

// *** verif/host_cmd_model.sv ***
`timescale 1ns/1ps
module host_cmd_model (
    input  wire logic          clk,
    output flash_sw_pkg::cmd_t cmd_op,
    output logic               cmd_valid,
    output logic [1:0]         cmd_reg_sel,
    output logic [7:0]         cmd_data,
    output logic [21:0]        cmd_addr
);
    // idle bus from time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = flash_sw_pkg::CMD_NOP;
        cmd_reg_sel = 2'h0;
        cmd_data = 8'h00;
        cmd_addr = 22'h000000;
    end
    // one word, valid for exactly one rising edge
    // quad mode is only asked for by the bench while both pins are driven, never tied
    task automatic issue(input flash_sw_pkg::cmd_t op, input logic [1:0] sel, input logic [7:0] d,
                         input logic [21:0] a);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_reg_sel = sel;
        cmd_data = d;
        cmd_addr = a;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_data = ~d; // stale fields must not look like the last word
        cmd_addr = ~a;
    endtask
endmodule

// *** verif/flash_status_write_protect_bench.sv ***
`timescale 1ns/1ps
module flash_status_write_protect_bench;
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               cmd_valid;
    flash_sw_pkg::cmd_t cmd_op;
    logic [1:0]         cmd_reg_sel;
    logic [7:0]         cmd_data, s_low, s_mid, s_high, r;
    logic [21:0]        cmd_addr;
    logic               guard_n = 1'b1;
    logic               pause_n = 1'b1;
    logic               busy, done, refused, quad, paused;
    logic               exp_q[$];
    int                 miscompares = 0;
    int                 n_tests = 0;
    int                 seed = 16327;

    host_cmd_model i_host_cmd_model (.clk(clk), .cmd_op(cmd_op), .cmd_valid(cmd_valid),
        .cmd_reg_sel(cmd_reg_sel), .cmd_data(cmd_data), .cmd_addr(cmd_addr));
    // short op times keep the run brief; sector erase is only ever refused here, so it keeps its own time
    flash_status_write_protect #(.SR_WRITE_CYCLES(5), .PAGE_CYCLES(6),
        .BLOCK32_CYCLES(8), .BLOCK64_CYCLES(9), .CHIP_CYCLES(10)) i_flash_status_write_protect (
        .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_reg_sel(cmd_reg_sel), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
        .write_guard_pin_n(guard_n), .pause_pin_n(pause_n), .status_reg_low(s_low),
        .status_reg_mid(s_mid), .status_reg_high(s_high), .busy_flag(busy), .cmd_done(done),
        .cmd_refused(refused), .quad_lines_active(quad), .serial_paused(paused));

    // 4 ns clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // issue, note the answer, then wait out any busy time under a bound
    task automatic run(input flash_sw_pkg::cmd_t op, input logic [1:0] sel, input logic [7:0] d,
                       input logic [21:0] a, input logic ok);
        logic w;
        w = op inside {flash_sw_pkg::CMD_STATUS_WRITE_CMD, flash_sw_pkg::CMD_PAGE, flash_sw_pkg::CMD_SECTOR,
                       flash_sw_pkg::CMD_BLOCK32, flash_sw_pkg::CMD_BLOCK64, flash_sw_pkg::CMD_CHIP};
        exp_q.push_back(ok);
        i_host_cmd_model.issue(op, sel, d, a);
        if (w) chk("busy", {7'h0, ok}, {7'h0, busy});
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        if (w && ok) chk("latch", 8'h00, {7'h0, s_low[1]});
    endtask

    task automatic cmd(input flash_sw_pkg::cmd_t op, input logic [21:0] a, input logic ok);
        run(op, 2'h0, 8'h00, a, ok);
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic ok);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        run(flash_sw_pkg::CMD_STATUS_WRITE_CMD, sel, d, 22'h0, ok);
    endtask

    // pin change plus synchroniser delay
    task automatic pin(input logic v);
        guard_n = v;
        repeat (3) @(negedge clk);
    endtask

    task automatic power_cycle;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
    endtask

    // each answer pulse is matched with the oldest note
    always @(negedge clk) begin
        if (done === 1'b1 || refused === 1'b1) begin
            if (exp_q.size() == 0) chk("answer", 8'h00, 8'h01);
            else chk("answer", {7'h0, exp_q.pop_front()}, {7'h0, done});
        end
    end

    // watchdog, far beyond the expected few hundred cycles
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        chk("low", 8'h00, s_low);
        chk("mid", 8'h00, s_mid);
        chk("high", 8'h20, s_high);
        run(flash_sw_pkg::CMD_STATUS_WRITE_CMD, 2'h0, 8'h04, 22'h0, 1'b0);
        cmd(flash_sw_pkg::CMD_PAGE, 22'h0, 1'b0);
        chk("low", 8'h00, s_low);
        $display("end reset and latch");
        wr(2'h0, 8'h07, 1'b1);
        chk("low", 8'h04, s_low);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        cmd(flash_sw_pkg::CMD_SECTOR, 22'h3f0000, 1'b0);
        cmd(flash_sw_pkg::CMD_BLOCK32, 22'h3f8000, 1'b0);
        cmd(flash_sw_pkg::CMD_CHIP, 22'h0, 1'b0);
        cmd(flash_sw_pkg::CMD_BLOCK64, 22'h3effff, 1'b1);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        cmd(flash_sw_pkg::CMD_WRDI, 22'h0, 1'b1);
        cmd(flash_sw_pkg::CMD_PAGE, 22'h0, 1'b0);
        $display("end plain guard");
        wr(2'h1, 8'h40, 1'b1);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        cmd(flash_sw_pkg::CMD_PAGE, 22'h3effff, 1'b0);
        cmd(flash_sw_pkg::CMD_PAGE, 22'h3f0000, 1'b1);
        wr(2'h0, 8'h1c, 1'b1);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        cmd(flash_sw_pkg::CMD_CHIP, 22'h0, 1'b1);
        $display("end complement");
        pin(1'b0);
        wr(2'h0, 8'h80, 1'b1);
        wr(2'h0, 8'h84, 1'b0);
        chk("low", 8'h82, s_low);
        pin(1'b1);
        wr(2'h1, 8'h01, 1'b1);
        wr(2'h2, 8'h00, 1'b0);
        power_cycle();
        wr(2'h1, 8'h01, 1'b1);
        wr(2'h0, 8'h04, 1'b0);
        power_cycle();
        chk("mid", 8'h00, s_mid);
        $display("end lock modes");
        pause_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("paused", 8'h01, {7'h0, paused});
        wr(2'h1, 8'h02, 1'b1);
        repeat (3) @(negedge clk);
        chk("quad", 8'h01, {7'h0, quad});
        chk("paused", 8'h00, {7'h0, paused});
        pause_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            r = 8'($random(seed));
            wr(2'h2, r, 1'b1);
            chk("high", r & 8'h61, s_high);
        end
        $display("end quad and third register");
        // program paused mid-flight and resumed to completion, then a second program cut short by a reset command
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        exp_q.push_back(1'b1);
        i_host_cmd_model.issue(flash_sw_pkg::CMD_PAGE, 2'h0, 8'h00, 22'h000100);
        cmd(flash_sw_pkg::CMD_SUSPEND, 22'h0, 1'b1);
        chk("mid", 8'h06, s_mid);
        chk("busy", 8'h00, {7'h0, busy});
        cmd(flash_sw_pkg::CMD_RESUME, 22'h0, 1'b1);
        chk("low", 8'h00, s_low);
        chk("mid", 8'h02, s_mid);
        cmd(flash_sw_pkg::CMD_WREN, 22'h0, 1'b1);
        exp_q.push_back(1'b1);
        i_host_cmd_model.issue(flash_sw_pkg::CMD_PAGE, 2'h0, 8'h00, 22'h000100);
        cmd(flash_sw_pkg::CMD_SWRESET, 22'h0, 1'b1);
        chk("low", 8'h00, s_low);
        cmd(flash_sw_pkg::CMD_RESUME, 22'h0, 1'b0);
        wr(2'h3, 8'h00, 1'b0);
        $display("end pause and reset");
        // with quad mode on the guard pin carries data and cannot lock
        pin(1'b0);
        wr(2'h0, 8'h80, 1'b1);
        wr(2'h0, 8'h84, 1'b1);
        chk("low", 8'h84, s_low);
        $display("end quad guard pin");
        repeat (3) @(negedge clk);
        end_sim();
    end
endmodule
